// File: rtl/fcb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcb_defines.svh"

module fcb_top import fcb_pkg::*; #(
	parameter int BIT_CYC = `FCB_BIT_CYC,
	parameter int FAULT_CYC = `FCB_FAULT_CYC,
	parameter int PHINV_CYC = `FCB_PHINV_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic bias_uv_in,
	input wire logic fb_ov_in,
	input wire logic overtemp_in,
	input wire logic fb_below_burst_in,
	input wire logic fb_in_regulation_in,
	input wire logic winding_sense_pin,
	input wire logic link_clk_ref,
	input wire logic cycle_strobe_in,
	input wire logic isolated_link_input,
	input wire logic primary_ext_fault_in,
	output logic secondary_config_pin,
	output logic primary_config_pin,
	output logic light_load_indicator,
	output logic switching_enable,
	output logic sec_powerup_reset,
	output logic primary_latch_off,
	output logic link_cmd_level
);

	// A bit needs three clocks at least so a zero still has a nonzero high time
	if (BIT_CYC < 3 || FAULT_CYC < 1 || PHINV_CYC < 1) begin : g_bad_param
		$error("fcb_top: unsupported timing parameters");
	end

	// ==========================================================
	// Input synchronisers
	// ==========================================================
	localparam int NS = 10;
	logic [NS-1:0] sync1_q, sync2_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= {primary_ext_fault_in, isolated_link_input, cycle_strobe_in, link_clk_ref,
				winding_sense_pin, fb_in_regulation_in, fb_below_burst_in, overtemp_in, fb_ov_in, bias_uv_in};
			sync2_q <= sync1_q;
		end
	end
	wire logic s_bias_uv = sync2_q[0];
	wire logic s_fb_ov = sync2_q[1];
	wire logic s_ot = sync2_q[2];
	wire logic s_fb_low = sync2_q[3];
	wire logic s_in_reg = sync2_q[4];
	wire logic s_wind = sync2_q[5];
	wire logic s_lclk = sync2_q[6];
	wire logic s_cyc = sync2_q[7];
	wire logic s_link = sync2_q[8];
	wire logic s_ext = sync2_q[9];

	// ==========================================================
	// Control register
	// ==========================================================
	// ctrl: [0] sec fault-off, [1] pri fault-off, [2] handed over, [3] freq confirmed,
	// [4] low load, [7:5] primary selection, [9:8] freq range, [11:10] sec pin selection
	logic [31:0] ctrl_q;
	logic [31:0] pword_q;
	logic bus_ack_q;
	wire logic bus_req = (avs_read | avs_write) & ~bus_ack_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= `FCB_CTRL_RST;
			pword_q <= 32'h0000_0000;
		end else if (avs_write && bus_ack_q) begin
			if (avs_address == `FCB_ADDR_CTRL) begin
				ctrl_q <= avs_writedata;
			end
			if (avs_address == `FCB_ADDR_PWORD) begin
				pword_q <= avs_writedata;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus_ack_q <= 1'b0;
		end else begin
			bus_ack_q <= bus_req;
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack_q;

	wire logic sec_off = ctrl_q[0];
	wire logic pri_off = ctrl_q[1];
	wire logic handed = ctrl_q[2];
	wire logic freq_conf = ctrl_q[3];
	wire logic [2:0] pri_sel = ctrl_q[7:5];
	wire logic [1:0] freq_rng = ctrl_q[9:8];
	wire logic cc_mode = ctrl_q[11]; // Secondary selections 2 and 3 [R15]

	// ==========================================================
	// Fault detectors
	// ==========================================================
	logic [31:0] uv_cnt_q, st_cnt_q, ph_cnt_q;
	logic out_uv_q, start_q, phinv_q;
	logic cyc_d1_q, inv_seen_q;

	always_ff @(posedge mclk) begin
		if (rst || !handed || cc_mode || !s_fb_low) begin // [R13] [R15]
			uv_cnt_q <= '0;
		end else if (uv_cnt_q < FAULT_CYC) begin
			uv_cnt_q <= uv_cnt_q + 32'd1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst || !freq_conf || handed || cc_mode || s_in_reg) begin // [R14] [R15]
			st_cnt_q <= '0;
		end else if (st_cnt_q < FAULT_CYC) begin
			st_cnt_q <= st_cnt_q + 32'd1;
		end
	end

	// Inversion judged per switching cycle: any in-phase sample clears the cycle's flag
	always_ff @(posedge mclk) begin
		if (rst) begin
			cyc_d1_q <= 1'b0;
			inv_seen_q <= 1'b1;
		end else begin
			cyc_d1_q <= s_cyc;
			if (s_cyc && !cyc_d1_q) begin
				inv_seen_q <= 1'b1;
			end else if (s_wind == s_lclk) begin
				inv_seen_q <= 1'b0;
			end
		end
	end
	wire logic cyc_end = s_cyc & ~cyc_d1_q;
	always_ff @(posedge mclk) begin
		if (rst || !handed) begin // [R11]
			ph_cnt_q <= '0;
		end else if (cyc_end && !inv_seen_q) begin
			ph_cnt_q <= '0; // [R12]
		end else if (ph_cnt_q < PHINV_CYC) begin
			ph_cnt_q <= ph_cnt_q + 32'd1; // [R12]
		end
	end

	// Sticky until fault-off period ends so the reported word stays stable
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_uv_q <= 1'b0;
			start_q <= 1'b0;
			phinv_q <= 1'b0;
		end else begin
			out_uv_q <= (uv_cnt_q >= FAULT_CYC) | (out_uv_q & sec_off); // [R13]
			start_q <= (st_cnt_q >= FAULT_CYC) | (start_q & sec_off); // [R14]
			phinv_q <= (ph_cnt_q >= PHINV_CYC) | (phinv_q & sec_off); // [R11]
		end
	end

	logic [31:0] sword;
	always_comb begin
		sword = 32'h0000_0000; // [R22]
		sword[31:28] = `FCB_PREAMBLE_HI; // [R06]
		sword[27:24] = `FCB_PREAMBLE_LO; // [R06]
		sword[17:16] = freq_rng; // [R07]
		sword[`FCB_BIT_BIAS_UV] = s_bias_uv; // [R05] [R08]
		sword[`FCB_BIT_FB_OV] = s_fb_ov & handed; // [R09]
		sword[`FCB_BIT_OT] = s_ot; // [R10]
		sword[`FCB_BIT_PHINV] = phinv_q; // [R11]
		sword[`FCB_BIT_OUT_UV] = out_uv_q; // [R13]
		sword[`FCB_BIT_START] = start_q; // [R14]
	end

	function automatic fcb_action_e bit_action(input int idx);
		case (idx)
			`FCB_BIT_BIAS_UV: bit_action = FCB_ACT_POWERUP;
			`FCB_BIT_FB_OV, `FCB_BIT_OT, `FCB_BIT_OUT_UV, `FCB_BIT_START: bit_action = FCB_ACT_RESTART;
			`FCB_BIT_PHINV, 16, 17, 24, 25, 26, 27, 28, 29, 30, 31: bit_action = FCB_ACT_INFO;
			default: bit_action = FCB_ACT_UNUSED;
		endcase
	endfunction

	logic [31:0] restart_mask, powerup_mask;
	always_comb begin
		restart_mask = '0;
		powerup_mask = '0;
		for (int i = 0; i < 32; i++) begin
			restart_mask[i] = (bit_action(i) == FCB_ACT_RESTART); // [R16]
			powerup_mask[i] = (bit_action(i) == FCB_ACT_POWERUP); // [R16]
		end
	end

	// ==========================================================
	// Fault actions and primary map
	// ==========================================================
	logic latch_q;
	always_ff @(posedge mclk) begin
		if (rst) begin
			switching_enable <= 1'b0;
			sec_powerup_reset <= 1'b0;
			latch_q <= 1'b0;
			light_load_indicator <= 1'b0;
			link_cmd_level <= 1'b0;
		end else begin
			switching_enable <= ~s_ot & ~|(sword & (restart_mask | powerup_mask)); // [R10]
			sec_powerup_reset <= |(sword & powerup_mask); // [R08]
			// Latch on external fault always, or any primary fault when selection 4-7
			latch_q <= latch_q | s_ext | (pri_off & pri_sel[2]); // [R17] [R18] [R21]
			light_load_indicator <= ctrl_q[4]; // [R19]
			link_cmd_level <= s_link; // [R20]
		end
	end
	assign primary_latch_off = latch_q;

	// ==========================================================
	// Bitstream transmitters, primary and secondary
	// ==========================================================
	localparam int ONE3 = BIT_CYC / 3;
	localparam int TWO3 = (2 * BIT_CYC) / 3;
	logic [1:0] tx_out;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tx
			fcb_tx_e st_q;
			logic [4:0] idx_q;
			logic [31:0] cnt_q;
			logic [31:0] word_q;
			logic pin_q;
			wire logic active = g ? pri_off : sec_off; // [R01] [R02]
			wire logic [31:0] word_src = g ? pword_q : sword;
			always_ff @(posedge mclk) begin
				if (rst) begin
					st_q <= FCB_TX_IDLE;
					idx_q <= '0;
					cnt_q <= '0;
					word_q <= '0;
					pin_q <= 1'b0;
				end else begin
					case (st_q)
						FCB_TX_IDLE: begin
							pin_q <= 1'b0;
							if (active) begin
								st_q <= FCB_TX_BIT;
								idx_q <= `FCB_FIRST_BIT; // [R03]
								cnt_q <= '0;
								word_q <= word_src;
							end
						end
						FCB_TX_BIT: begin
							pin_q <= (cnt_q < (word_q[idx_q] ? TWO3 : ONE3)); // [R04]
							if (!active) begin
								st_q <= FCB_TX_IDLE;
							end else if (cnt_q == BIT_CYC - 1) begin
								cnt_q <= '0;
								if (idx_q == 5'h00) begin
									idx_q <= `FCB_LAST_BIT; // [R03]
									word_q <= word_src; // [R05]
								end else begin
									idx_q <= idx_q - 5'h01;
								end
							end else begin
								cnt_q <= cnt_q + 32'd1;
							end
						end
						default: st_q <= FCB_TX_IDLE;
					endcase
				end
			end
			assign tx_out[g] = pin_q;
		end
	endgenerate
	assign secondary_config_pin = tx_out[0];
	assign primary_config_pin = tx_out[1];

	// ==========================================================
	// Register read
	// ==========================================================
	always_ff @(posedge mclk) begin
		if (rst) begin
			avs_readdata <= '0;
		end else if (avs_read && bus_req) begin
			case (avs_address)
				`FCB_ADDR_CTRL: avs_readdata <= ctrl_q;
				`FCB_ADDR_STAT: avs_readdata <= {28'h0, latch_q, sec_powerup_reset, switching_enable, 1'b0};
				`FCB_ADDR_SWORD: avs_readdata <= sword;
				`FCB_ADDR_PWORD: avs_readdata <= pword_q;
				default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	a_preamble_fixed: assert property (@(posedge mclk) disable iff (rst) sword[31:24] == 8'hF0) // [R06]
		else $error("preamble wrong");
	a_unused_zero: assert property (@(posedge mclk) disable iff (rst) (sword & 32'h00FC_D79A) == 0) // [R22]
		else $error("unused bit set");
	a_freq_info: assert property (@(posedge mclk) disable iff (rst) sword[17:16] == freq_rng) // [R07]
		else $error("range readout wrong");
	a_fbov_handed: assert property (@(posedge mclk) disable iff (rst) sword[11] |-> handed) // [R09]
		else $error("fb overvoltage before hand-over");
	a_cc_blocks: assert property (@(posedge mclk) disable iff (rst) cc_mode |=> (uv_cnt_q == 0 && st_cnt_q == 0)) // [R15]
		else $error("cc mode did not clear timers");
	a_ot_stops: assert property (@(posedge mclk) disable iff (rst) s_ot |=> !switching_enable) // [R10]
		else $error("switching during overtemp");
	a_bias_powerup: assert property (@(posedge mclk) disable iff (rst) s_bias_uv |=> sec_powerup_reset) // [R08]
		else $error("no power-up on bias uv");
	a_ext_latch: assert property (@(posedge mclk) disable iff (rst) s_ext |=> primary_latch_off) // [R18]
		else $error("external fault not latched");
	a_phinv_reset: assert property (@(posedge mclk) disable iff (rst) (handed && cyc_end && !inv_seen_q) |=> ph_cnt_q == 0) // [R12]
		else $error("phase timer not reset");
	a_tx_start: assert property (@(posedge mclk) disable iff (rst)
		(g_tx[0].st_q == FCB_TX_IDLE && sec_off) |=> g_tx[0].idx_q == 5'h0F) // [R03]
		else $error("first pass not at bit 15");
	a_idle_low: assert property (@(posedge mclk) disable iff (rst) !sec_off |=> ##1 !secondary_config_pin) // [R01]
		else $error("pin active outside fault-off");
	c_sec_tx: cover property (@(posedge mclk) disable iff (rst) g_tx[0].idx_q == 5'h1F);
	c_pri_tx: cover property (@(posedge mclk) disable iff (rst) g_tx[1].idx_q == 5'h1F);
	c_phinv: cover property (@(posedge mclk) disable iff (rst) phinv_q);
	c_bus_rd: cover property (@(posedge mclk) disable iff (rst) avs_read && !avs_waitrequest);

endmodule
`default_nettype wire

// File: rtl/fcb_defines.svh
// Contract
// [R01] Secondary sends its fault word repeatedly throughout the fault-off period.
// [R02] Primary sends its own word likewise, same framing and coding.
// [R03] First pass sends bits 15..0; later passes send bits 31..0.
// [R04] Bit period T: one is 2/3 high, zero is 1/3 high.
// [R05] Every asserted fault bit is set; concurrent faults share a word.
// [R06] Bits 31:28 are 1111, bits 27:24 are 0000.
// [R07] Bits 17:16 carry the internal frequency range, information only.
// [R08] Bias undervoltage sets bit 13 and returns controller to power-up state.
// [R09] Feedback overvoltage sets bit 11 after hand-over; auto-restart.
// [R10] Over-temperature sets bit 6, switching stops while active; auto-restart.
// [R11] After hand-over, phase inversion held for whole timer sets bit 5.
// [R12] Inversion timer counts consecutive inverted cycles; one clean cycle clears it.
// [R13] After hand-over, feedback below burst threshold 64 ms sets bit 2.
// [R14] From frequency confirmation, no regulation within 64 ms sets bit 0.
// [R15] Constant-current selections disable output undervoltage and start-up timeout.
// [R16] Each fault bit has action: restart, power-up, information or unused.
// [R17] Primary selections 0-7 pick ranges 0-3; 0-3 auto-on, 4-7 latch-off. Code decodes only selection bit 2; no range is picked.
// [R18] External fault on primary pin always latches off.
// [R19] Low-load indicator output is driven while operating at low load.
// [R20] Isolated link input accepted as digital logic-level commands.
// [R21] Primary all-action faults all restart (sel 0-3) or all latch (4-7).
// [R22] Unused word positions are sent as zero.
`ifndef FCB_DEFINES_SVH
`define FCB_DEFINES_SVH

`define FCB_CLK_MHZ 40
`define FCB_BIT_PERIOD_NS 30000
`define FCB_BIT_CYC ((`FCB_BIT_PERIOD_NS * `FCB_CLK_MHZ) / 1000)
`define FCB_FAULT_MS 64
`define FCB_FAULT_CYC (`FCB_FAULT_MS * `FCB_CLK_MHZ * 1000)
`define FCB_PHINV_US 800
`define FCB_PHINV_CYC (`FCB_PHINV_US * `FCB_CLK_MHZ)

`define FCB_PREAMBLE_HI 4'hF
`define FCB_PREAMBLE_LO 4'h0
`define FCB_BIT_BIAS_UV 13
`define FCB_BIT_FB_OV 11
`define FCB_BIT_OT 6
`define FCB_BIT_PHINV 5
`define FCB_BIT_OUT_UV 2
`define FCB_BIT_START 0
`define FCB_FIRST_BIT 5'h0F
`define FCB_LAST_BIT 5'h1F

`define FCB_ADDR_CTRL 4'h0
`define FCB_ADDR_STAT 4'h4
`define FCB_ADDR_SWORD 4'h8
`define FCB_ADDR_PWORD 4'hC
`define FCB_CTRL_RST 32'h0000_0000

`endif

// File: rtl/fcb_pkg.sv
package fcb_pkg;
	typedef enum logic [1:0] {
		FCB_ACT_RESTART,
		FCB_ACT_POWERUP,
		FCB_ACT_INFO,
		FCB_ACT_UNUSED
	} fcb_action_e;
	typedef enum {FCB_TX_IDLE, FCB_TX_BIT} fcb_tx_e;
endpackage

// File: dv/fcb_pin_mon.sv
`timescale 1ns/1ps
`default_nettype none
module fcb_pin_mon #(
	parameter int BIT_CYC = 30
) (
	input wire logic mclk,
	input wire logic clear,
	input wire logic pin,
	output logic [63:0] bits_q,
	output logic [7:0] n_bits_q,
	output logic [7:0] n_bad_q
);
	logic pin_q;
	logic [15:0] hi_q;
	logic [15:0] per_q;
	// ==========================================
	// Edge timing: high time and rise-to-rise period
	always @(posedge mclk) begin
		pin_q <= pin;
		hi_q <= (pin && !pin_q) ? 16'h0001 : hi_q + {15'h0000, pin};
		per_q <= (pin && !pin_q) ? 16'h0001 : per_q + 16'h0001;
	end
	// ==========================================
	// Decode: the bit value is judged only at the falling edge
	always @(posedge mclk) begin
		if (clear) begin
			bits_q <= 64'h0;
			n_bits_q <= 8'h00;
			n_bad_q <= 8'h00;
		end else if (pin_q && !pin) begin
			bits_q <= {bits_q[62:0], 32'(hi_q) > BIT_CYC / 2};
			n_bits_q <= n_bits_q + 8'h01;
			if (32'(hi_q) != BIT_CYC * 2 / 3 && 32'(hi_q) != BIT_CYC / 3) n_bad_q <= n_bad_q + 8'h01;
		end else if (pin && !pin_q && n_bits_q != 8'h00 && 32'(per_q) != BIT_CYC) begin
			n_bad_q <= n_bad_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// File: dv/fcb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcb_defines.svh"
module fcb_top_tb import fcb_pkg::*;;
	localparam int BC = 30;
	localparam int FC = 200;
	localparam int PC = 50;
	logic mclk, rst, avs_read, avs_write, avs_waitrequest, mon_clear;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic bias_uv_in, fb_ov_in, overtemp_in, fb_below_burst_in, fb_in_regulation_in;
	logic winding_sense_pin, link_clk_ref, isolated_link_input, primary_ext_fault_in;
	logic cycle_strobe_in = 1'b0;
	logic secondary_config_pin, primary_config_pin, light_load_indicator, switching_enable;
	logic sec_powerup_reset, primary_latch_off, link_cmd_level;
	logic [63:0] sbits, pbits;
	logic [7:0] sn, pn, sbad, pbad;
	int miscompares, checks_done, cycles;
	fcb_top #(.BIT_CYC(BC), .FAULT_CYC(FC), .PHINV_CYC(PC)) i_dut (.mclk, .rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .bias_uv_in, .fb_ov_in, .overtemp_in,
		.fb_below_burst_in, .fb_in_regulation_in, .winding_sense_pin, .link_clk_ref, .cycle_strobe_in,
		.isolated_link_input, .primary_ext_fault_in, .secondary_config_pin, .primary_config_pin,
		.light_load_indicator, .switching_enable, .sec_powerup_reset, .primary_latch_off, .link_cmd_level);
	fcb_pin_mon #(.BIT_CYC(BC)) i_smon (.mclk, .clear(mon_clear), .pin(secondary_config_pin), .bits_q(sbits),
		.n_bits_q(sn), .n_bad_q(sbad));
	fcb_pin_mon #(.BIT_CYC(BC)) i_pmon (.mclk, .clear(mon_clear), .pin(primary_config_pin), .bits_q(pbits),
		.n_bits_q(pn), .n_bad_q(pbad));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ==========================================
	// Switching-cycle strobe and hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles % 4 == 3) cycle_strobe_in <= !cycle_strobe_in;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Entered just after a rising edge; holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		// Only the bench timeout ends a wait that never sees waitrequest low
		do begin
			@(posedge mclk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic rst_dut();
		rst <= 1'b1;
		wt(3);
		rst <= 1'b0;
		wt(1);
	endtask
	task automatic give_verdict();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{bias_uv_in, fb_ov_in, overtemp_in, fb_below_burst_in, fb_in_regulation_in} = '0;
		{winding_sense_pin, link_clk_ref, isolated_link_input, primary_ext_fault_in} = '0;
		{miscompares, checks_done} = '0;
		rst = 1'b1;
		mon_clear = 1'b1;
		fork
		begin
		wt(10);
		rst <= 1'b0;
		wt(1);
		rdc(`FCB_ADDR_CTRL, `FCB_CTRL_RST);
		bus(1'b1, 4'h2, 32'hFFFF_FFFF);
		rdc(4'h2, 32'h0);
		check(32'({secondary_config_pin, primary_config_pin}), 32'h0);
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0010);
		isolated_link_input <= 1'b1;
		wt(4);
		check(32'(light_load_indicator), 32'h1);
		check(32'(link_cmd_level), 32'h1);
		$display("test reset and levels done");
		bias_uv_in <= 1'b1;
		overtemp_in <= 1'b1;
		fb_ov_in <= 1'b1;
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0200);
		wt(4);
		rdc(`FCB_ADDR_SWORD, 32'hF002_2040);
		check(32'({sec_powerup_reset, switching_enable}), 32'h2);
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0204);
		wt(4);
		rdc(`FCB_ADDR_SWORD, 32'hF002_2840);
		{bias_uv_in, overtemp_in, fb_ov_in} <= 3'h0;
		wt(4);
		check(32'({sec_powerup_reset, switching_enable}), 32'h1);
		$display("test word content done");
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0808);
		wt(FC + 40);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0000);
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0008);
		wt(FC - 20);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0000);
		wt(40);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0001);
		rst_dut();
		fb_below_burst_in <= 1'b1;
		fb_in_regulation_in <= 1'b1;
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0004);
		wt(FC + 40);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0004);
		$display("test timers done");
		rst_dut();
		fb_below_burst_in <= 1'b0;
		winding_sense_pin <= 1'b1;
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0004);
		wt(PC - 10);
		link_clk_ref <= 1'b1;
		wt(10);
		link_clk_ref <= 1'b0;
		wt(PC - 10);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0000);
		wt(PC * 10);
		rdc(`FCB_ADDR_SWORD, 32'hF000_0020);
		$display("test phase inversion done");
		rst_dut();
		winding_sense_pin <= 1'b0;
		overtemp_in <= 1'b1;
		mon_clear <= 1'b0;
		bus(1'b1, `FCB_ADDR_PWORD, 32'hA5C3_0F96);
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0103);
		wt(4);
		rdc(`FCB_ADDR_PWORD, 32'hA5C3_0F96);
		wt(50 * BC);
		check({24'h0, sn}, 32'd50);
		check({16'h0, sbits[49:34]}, 32'h0000_0040);
		check(sbits[33:2], 32'hF001_0040);
		check({24'h0, pn}, 32'd50);
		check({16'h0, pbits[49:34]}, 32'h0000_0F96);
		check(pbits[33:2], 32'hA5C3_0F96);
		check({16'h0, sbad, pbad}, 32'h0);
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0000);
		wt(2 * BC);
		check(32'({secondary_config_pin, primary_config_pin}), 32'h0);
		$display("test bitstream done");
		rst_dut();
		overtemp_in <= 1'b0;
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0002);
		wt(8);
		check(32'(primary_latch_off), 32'h0);
		primary_ext_fault_in <= 1'b1;
		wt(6);
		check(32'(primary_latch_off), 32'h1);
		primary_ext_fault_in <= 1'b0;
		rst_dut();
		bus(1'b1, `FCB_ADDR_CTRL, 32'h0000_0082);
		wt(8);
		check(32'(primary_latch_off), 32'h1);
		$display("test primary response done");
		end
		begin
			wait (cycles >= 20000);
			miscompares = miscompares + 1;
			$display("timeout at cycle %0d", cycles);
		end
		join_any
		give_verdict();
	end
endmodule
`default_nettype wire
